//--- verification/apt_pm1_control_timer_bench.sv
// Bench for the power management control register and timer block.
// Drives every port itself; timer built narrow so bit-top carry is reached.
`timescale 1ns/10ps
module apt_pm1_control_timer_bench;
    import apt_pkg::*;
    localparam int W = 10;
    logic i_sys_clk, i_rst, mr, tb, work, smi_route_enable, bm, c_en, f_en, f_clr, t_clr;
    apt_req_s i_req;
    logic [7:0] o_rdata;
    logic rv, fsts, tsts;
    apt_irq_s o_irq;
    logic [23:0] cnt;
    int n_errors, checks, cyc;

    apt_pm1_control_timer #(.CNT_WIDTH(W)) i_dut (.i_sys_clk(i_sys_clk),
        .i_rst(i_rst), .i_master_reset(mr), .i_timebase_clock_input(tb),
        .i_working_state(work), .i_req(i_req), .i_smi_route_enable(smi_route_enable),
        .i_bus_master_control(bm), .i_timer_carry_enable(c_en),
        .i_firmware_event_enable(f_en), .i_firmware_status_clear(f_clr),
        .i_timer_status_clear(t_clr), .o_rdata(o_rdata), .o_rvalid(rv),
        .o_firmware_event_status(fsts), .o_timer_carry_status(tsts),
        .o_irq(o_irq));

    // Free-running clock, 4 ns period
    initial begin
        i_sys_clk = 1'b0;
        forever #2 i_sys_clk = ~i_sys_clk;
    end

    task automatic summarize();
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Guard against a hung handshake; tests need about 3500 cycles
    always @(posedge i_sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            summarize();
        end
    end

    task automatic cmp8(string nm, logic [7:0] e, logic [7:0] g);
        checks++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask

    task automatic cmp1(string nm, logic e, logic g);
        checks++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] %s exp %b got %b", nm, e, g);
        end
    endtask

    task automatic wr(logic [3:0] a, logic [7:0] d);
        @(posedge i_sys_clk) i_req <= {1'b0, 1'b1, a, d};
        @(posedge i_sys_clk) i_req <= '0;
        repeat (3) @(posedge i_sys_clk);
    endtask

    // Read one byte; answer may land one or two edges after the request
    task automatic rd(logic [3:0] a, logic [7:0] e);
        @(posedge i_sys_clk) i_req <= {1'b1, 1'b0, a, 8'h00};
        @(posedge i_sys_clk) i_req <= '0;
        #1;
        if (rv !== 1'b1) begin
            @(posedge i_sys_clk);
            #1;
        end
        cmp1("rvalid", 1'b1, rv);
        cmp8("rdata", e, o_rdata);
    endtask

    // One-cycle clear strobe: timer carry clear when sel, else firmware
    task automatic pulse(bit sel);
        @(posedge i_sys_clk)
        if (sel) t_clr <= 1'b1;
        else f_clr <= 1'b1;
        @(posedge i_sys_clk) {f_clr, t_clr} <= 2'b00;
        repeat (3) @(posedge i_sys_clk);
    endtask

    // Timebase edges four system cycles apart; only counted while working
    task automatic tick(int n);
        repeat (n) begin
            @(posedge i_sys_clk) tb <= 1'b1;
            @(posedge i_sys_clk);
            @(posedge i_sys_clk) tb <= 1'b0;
            @(posedge i_sys_clk);
            if (work) cnt++;
        end
        repeat (6) @(posedge i_sys_clk);
    endtask

    task automatic chk_timer();
        rd(OFS_TIMER_BYTE0, cnt[7:0]);
        rd(OFS_TIMER_BYTE1, cnt[15:8]);
    endtask

    initial begin
        {i_rst, mr, tb, work, smi_route_enable, bm, c_en, f_en, f_clr, t_clr} = 10'h200;
        i_req = '0;
        cnt = '0;
        {n_errors, checks, cyc} = '0;
        repeat (20) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        // Reset values, reserved places and read-only timer bytes
        for (int a = 3; a < 10; a++) begin
            wr(4'(a), 8'hff);
            rd(4'(a), a == 4 ? 8'h07 : 8'h00);
            if (a == 4) wr(OFS_CONTROL_MAIN, 8'h00);
        end
        cmp1("fw status", 1'b1, fsts);
        cmp1("smi", 1'b0, o_irq.smi);
        wr(OFS_CONTROL_MAIN, 8'h04);
        pulse(1'b0);
        cmp1("fw status", 1'b0, fsts);
        rd(OFS_CONTROL_MAIN, 8'h00);
        f_en <= 1'b1;
        wr(OFS_CONTROL_MAIN, 8'h04);
        cmp1("smi", 1'b1, o_irq.smi);
        pulse(1'b0);
        // Bus master reload routes to SCI only with control set
        wr(OFS_CONTROL_MAIN, 8'h02);
        cmp1("sci", 1'b0, o_irq.sci);
        bm <= 1'b1;
        repeat (3) @(posedge i_sys_clk);
        cmp1("sci", 1'b1, o_irq.sci);
        bm <= 1'b0;
        // Counting, holding outside working state, stop and resume
        work <= 1'b1;
        tick(300);
        chk_timer();
        work <= 1'b0;
        tick(5);
        chk_timer();
        work <= 1'b1;
        repeat (50) @(posedge i_sys_clk);
        tick(2);
        chk_timer();
        @(posedge i_sys_clk) mr <= 1'b1;
        repeat (2) @(posedge i_sys_clk) mr <= 1'b0;
        cnt = '0;
        chk_timer();
        // Carry on top-bit toggle and its routing
        wr(OFS_CONTROL_MAIN, 8'h01);
        c_en <= 1'b1;
        tick(511);
        cmp1("carry", 1'b0, tsts);
        tick(1);
        cmp1("carry", 1'b1, tsts);
        cmp1("sci", 1'b1, o_irq.sci);
        smi_route_enable <= 1'b1;
        wr(OFS_CONTROL_MAIN, 8'h00);
        cmp8("irq", 8'(2'b01), 8'(o_irq));
        smi_route_enable <= 1'b0;
        repeat (3) @(posedge i_sys_clk);
        cmp8("irq", 8'h00, 8'(o_irq));
        pulse(1'b1);
        cmp1("carry", 1'b0, tsts);
        summarize();
    end
endmodule // apt_pm1_control_timer_bench

//--- verilog/apt_pkg.sv
// Package for the power management control and timer block.
// Assumes a byte-wide system I/O register port relative to a block base.
package apt_pkg;
    // Register offsets within the event block
    localparam logic [3:0] OFS_ENABLE_UPPER   = 4'h3;
    localparam logic [3:0] OFS_CONTROL_MAIN   = 4'h4;
    localparam logic [3:0] OFS_CONTROL_SECOND = 4'h5;
    localparam logic [3:0] OFS_CONTROL_THIRD  = 4'h6;
    localparam logic [3:0] OFS_CONTROL_FOURTH = 4'h7;
    localparam logic [3:0] OFS_TIMER_BYTE0    = 4'h8;
    localparam logic [3:0] OFS_TIMER_BYTE1    = 4'h9;

    // Control register field positions
    localparam int BIT_SCI_SELECT     = 0;
    localparam int BIT_BM_RELOAD_EN   = 1;
    localparam int BIT_GLOBAL_RELEASE = 2;
    localparam logic [7:0] CONTROL_RESET = 8'h00;

    // Timer geometry
    localparam int TIMER_WIDTH   = 24;
    localparam int TIMER_TOP_BIT = 23;

    // System clock and timebase rates in Hz
    localparam longint SYS_CLK_HZ  = 250000000;
    localparam longint TIMEBASE_HZ = 3579545;

    // Register port request
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [3:0] addr;
        logic [7:0] wdata;
    } apt_req_s;

    // Interrupt outputs
    typedef struct packed {
        logic sci;
        logic smi;
    } apt_irq_s;
endpackage

//--- verilog/apt_pm1_control_timer.sv
// Power management control register and 24-bit free-running timer.
// Assumes register requests are synchronous and decoded to the block base;
// the timebase clock input is sampled on the system clock.
`timescale 1ns/10ps
module apt_pm1_control_timer
    import apt_pkg::*;
#(
    parameter int CNT_WIDTH = TIMER_WIDTH
)(
    input  wire logic       i_sys_clk,
    input  wire logic       i_rst,
    input  wire logic       i_master_reset,
    input  wire logic       i_timebase_clock_input,
    input  wire logic       i_working_state,
    input  wire apt_req_s   i_req,
    input  wire logic       i_smi_route_enable,
    input  wire logic       i_bus_master_control,
    input  wire logic       i_timer_carry_enable,
    input  wire logic       i_firmware_event_enable,
    input  wire logic       i_firmware_status_clear,
    input  wire logic       i_timer_status_clear,
    output logic [7:0]      o_rdata,
    output logic            o_rvalid,
    output logic            o_firmware_event_status,
    output logic            o_timer_carry_status,
    output apt_irq_s        o_irq
);

    // Narrow builds shorten the wait for the carry; both bytes need 9 bits
    initial
    begin
        if (CNT_WIDTH < 9 || CNT_WIDTH > TIMER_WIDTH)
            $error("CNT_WIDTH must lie between 9 and the timer width");
    end

    logic [CNT_WIDTH-1:0] timer_count_value;
    logic [TIMER_WIDTH-1:0] count_wide;
    logic                 sci_select;
    logic                 bus_master_reload_enable;
    logic                 global_release;
    logic                 timebase_q;
    logic                 timebase_tick;
    logic                 top_bit_q;
    logic                 top_toggle;
    logic                 release_rise;
    logic                 release_q;
    logic                 ctl_write;
    logic [7:0]           next_rdata;

    // Write strobe decode used by several processes
    function automatic logic hit(input apt_req_s r, input logic [3:0] a);
        return r.wr && (r.addr == a);
    endfunction

    assign ctl_write = hit(i_req, OFS_CONTROL_MAIN);

    // Count padded to full width so byte reads never index past the top
    assign count_wide = TIMER_WIDTH'(timer_count_value);

    // Rising edge of the sampled timebase is the count enable
    assign timebase_tick = i_timebase_clock_input && !timebase_q;

    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
            timebase_q <= 1'b0;
        else
            timebase_q <= i_timebase_clock_input;
    end

    // Count holds while the timebase stops; only reset or master reset clears it
    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst || i_master_reset)
            timer_count_value <= '0;
        else if (timebase_tick && i_working_state)
            timer_count_value <= timer_count_value + 1'b1;
    end

    // Top bit history for the toggle detector
    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst || i_master_reset)
            top_bit_q <= 1'b0;
        else
            top_bit_q <= timer_count_value[CNT_WIDTH-1];
    end

    // Top bit of the built width; bit 23 at the default width
    assign top_toggle = timer_count_value[CNT_WIDTH-1] ^ top_bit_q;

    // Carry status: a toggle in the clear cycle wins over the clear
    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
            o_timer_carry_status <= 1'b0;
        else if (top_toggle)
            o_timer_carry_status <= 1'b1;
        else if (i_timer_status_clear)
            o_timer_carry_status <= 1'b0;
    end

    // Control register; bits 3 to 7 are not stored
    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
        begin
            sci_select               <= CONTROL_RESET[BIT_SCI_SELECT];
            bus_master_reload_enable <= CONTROL_RESET[BIT_BM_RELOAD_EN];
        end
        else if (ctl_write)
        begin
            sci_select               <= i_req.wdata[BIT_SCI_SELECT];
            bus_master_reload_enable <= i_req.wdata[BIT_BM_RELOAD_EN];
        end
    end

    // Global release: a new set in the clear cycle wins over the clear
    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
            global_release <= CONTROL_RESET[BIT_GLOBAL_RELEASE];
        else if (ctl_write && i_req.wdata[BIT_GLOBAL_RELEASE])
            global_release <= 1'b1;
        else if (i_firmware_status_clear)
            global_release <= 1'b0;
        else if (ctl_write)
            global_release <= 1'b0;
    end

    assign release_rise = global_release && !release_q;

    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
            release_q <= 1'b0;
        else
            release_q <= global_release;
    end

    // Firmware status follows a release set; the firmware status clear strobe clears it
    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
            o_firmware_event_status <= 1'b0;
        else if (release_rise)
            o_firmware_event_status <= 1'b1;
        else if (i_firmware_status_clear)
            o_firmware_event_status <= 1'b0;
    end

    // Read mux; reserved offsets fall through to zero
    always_comb
    begin
        next_rdata = 8'h00;
        case (i_req.addr)
            OFS_CONTROL_MAIN:
            begin
                next_rdata[BIT_SCI_SELECT]     = sci_select;
                next_rdata[BIT_BM_RELOAD_EN]   = bus_master_reload_enable;
                next_rdata[BIT_GLOBAL_RELEASE] = global_release;
            end
            OFS_TIMER_BYTE0: next_rdata = count_wide[7:0];
            OFS_TIMER_BYTE1: next_rdata = count_wide[15:8];
            default:         next_rdata = 8'h00;
        endcase
    end

    // Read data is registered; one cycle after the read strobe
    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
        begin
            o_rdata  <= 8'h00;
            o_rvalid <= 1'b0;
        end
        else
        begin
            o_rvalid <= i_req.rd;
            if (i_req.rd)
                o_rdata <= next_rdata;
        end
    end

    // Interrupt levels; the event term is the carry event
    logic pm_event;
    assign pm_event = i_timer_carry_enable && o_timer_carry_status;

    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
            o_irq <= '0;
        else
        begin
            o_irq.sci <= (sci_select && pm_event)
                      || (bus_master_reload_enable
                          && i_bus_master_control);
            o_irq.smi <= (!sci_select && i_smi_route_enable
                          && pm_event)
                      || (global_release
                          && i_firmware_event_enable);
        end
    end

    a_reserved_zero: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        i_req.rd && (i_req.addr == OFS_CONTROL_SECOND
                     || i_req.addr == OFS_ENABLE_UPPER)
        |=> o_rdata == 8'h00)
        else $error("reserved read nonzero");
    a_sci_route: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        sci_select && pm_event |=> o_irq.sci)
        else $error("sci not raised");
    a_smi_route: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        !sci_select && i_smi_route_enable && pm_event |=> o_irq.smi)
        else $error("smi not raised");
    a_bm_reload: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        bus_master_reload_enable && i_bus_master_control |=> o_irq.sci)
        else $error("reload sci missing");
    a_release_status: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        $rose(global_release) |=> o_firmware_event_status)
        else $error("firmware status not set");
    a_release_smi: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        global_release && i_firmware_event_enable |=> o_irq.smi)
        else $error("release smi missing");
    a_timer_hold: assert property (@(posedge i_sys_clk)
        disable iff (i_rst || i_master_reset)
        !(timebase_tick && i_working_state) |=> $stable(timer_count_value))
        else $error("timer moved without tick");
    a_timer_step: assert property (@(posedge i_sys_clk)
        disable iff (i_rst || i_master_reset)
        timebase_tick && i_working_state
        |=> timer_count_value == $past(timer_count_value) + 1'b1)
        else $error("timer did not step");
    a_carry_set: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        top_toggle |=> o_timer_carry_status)
        else $error("carry status missing");
    a_no_route: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        !sci_select && !i_smi_route_enable && !global_release
        && !(bus_master_reload_enable && i_bus_master_control)
        |=> !o_irq.sci && !o_irq.smi)
        else $error("interrupt without route");

endmodule // apt_pm1_control_timer
